// file: hdl/loop_dither_pkg.sv
/*
 * shared constants and frame layout for the per-channel loop, setpoint and dither settings store.
 * assumes a 32-bit command frame is delivered whole, one frame per strobe, on the main clock.
 */
package loop_dither_pkg;

    localparam int NUM_CHANNELS = 8;
    localparam int CLK_HZ = 20_000_000;

    // frame fields
    localparam int FRAME_W = 32;
    localparam int RW_BIT = 31;
    localparam logic RW_READ = 1'b0;
    localparam logic RW_WRITE = 1'b1;

    // message identifiers
    localparam logic [3:0] MSG_LOOP_GAIN = 4'h2;
    localparam logic [3:0] MSG_SETPOINT = 4'h3;
    localparam logic [3:0] MSG_DITHER_PERIOD = 4'h4;

    // field positions inside the 24-bit body
    localparam int KP_LSB = 12;
    localparam int KP_W = 12;
    localparam int KI_LSB = 0;
    localparam int KI_W = 12;
    localparam int HOLD_BIT = 23;
    localparam int STEP_LSB = 11;
    localparam int STEP_W = 11;
    localparam int SETPT_LSB = 0;
    localparam int SETPT_W = 11;
    localparam int NSTEPS_LSB = 0;
    localparam int NSTEPS_W = 5;

    // reset values
    localparam logic [11:0] KP_RST = 12'h000;
    localparam logic [11:0] KI_RST = 12'h000;
    localparam logic HOLD_RST = 1'b0;
    localparam logic [10:0] STEP_RST = 11'h000;
    localparam logic [10:0] SETPT_RST = 11'h000;
    localparam logic [4:0] NSTEPS_RST = 5'h00;

    // pwm period timing: n clocks per sample, m samples per period
    localparam int DIV_N_RST = 625;
    localparam int DIV_M_RST = 32;
    localparam int PWM_CYC = DIV_N_RST * DIV_M_RST;
    localparam int PWM_CNT_W = 24;

    // target current in quarter setpoint units, signed
    localparam int TARGET_W = 18;

    typedef struct packed {
        logic rw;
        logic [3:0] message_identifier;
        logic [2:0] channel_select;
        logic [23:0] body;
    } frame_t;

endpackage

// file: hdl/dither_wave.sv
/*
 * triangular dither generator for one channel, stepping once per pwm period.
 * assumes i_pwm_tick is a one-cycle enable on the main clock.
 */
`timescale 1ns/1ps
module dither_wave
    import loop_dither_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_pwm_tick,
    input wire logic [STEP_W-1:0] i_step,
    input wire logic [NSTEPS_W-1:0] i_nsteps,
    input wire logic [SETPT_W-1:0] i_setpoint,
    output logic signed [TARGET_W-1:0] o_target
);
    logic signed [6:0] pos_r;
    logic up_r;
    logic dither_on;
    logic signed [6:0] lim;
    logic signed [TARGET_W-1:0] offset;
    logic signed [TARGET_W-1:0] base;

    // zero step size or zero step count kills dither
    assign dither_on = (i_step != '0) && (i_nsteps != '0);
    assign lim = $signed({2'b00, i_nsteps});
    // offset swings +-step*steps, so peak to peak is 2*step*steps quarter units
    assign offset = TARGET_W'(pos_r * $signed({1'b0, i_step}));
    // one setpoint unit is four step units
    assign base = $signed({5'b0_0000, i_setpoint, 2'b00});

    // a full triangle is four quarters of nsteps pwm periods each
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pos_r <= '0;
            up_r <= 1'b1;
        end else if (!dither_on) begin
            pos_r <= '0;
            up_r <= 1'b1;
        end else if (i_pwm_tick) begin
            if (up_r && pos_r >= lim - 7'sd1) begin
                up_r <= 1'b0;
            end else if (!up_r && pos_r <= 7'sd1 - lim) begin
                up_r <= 1'b1;
            end
            pos_r <= up_r ? pos_r + 7'sd1 : pos_r - 7'sd1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_target <= '0;
        end else begin
            o_target <= base + offset;
        end
    end
endmodule

// file: hdl/loop_dither_settings.sv
/*
 * per-channel store of loop gains, setpoint with dither step and hold option, and dither step count,
 * reached by 32-bit command frames; answers each frame with a response frame one cycle later.
 * assumes the frame transport delivers a whole frame with a one-cycle strobe on the main clock.
 */
// What this block does
// - identifier 0010 in bits 30:27 selects gains of channel in bits 26:24.
// - proportional gain, 12 bits from 23:12, resets to zero.
// - integral gain, 12 bits from 11:0, resets to zero.
// - identifier 0011 selects setpoint and dither step of channel.
// - bit 23 set keeps channel regulating when global enable drops; reset clear.
// - 11-bit dither step from 21:11, resets zero, unit is quarter setpoint.
// - zero dither step means no dither on that channel.
// - 11-bit setpoint from 10:0, resets zero, scaled by 2^11.
// - dither peak to peak is two times step times steps over 2^13.
// - identifier 0100 selects five-bit dither step count in bits 4:0.
// - step count per quarter wave, resets zero, zero disables, period four counts.
// - pwm period is n times m main clocks, n resets to 625.
`timescale 1ns/1ps
module loop_dither_settings
    import loop_dither_pkg::*;
#(
    parameter int DIV_N = DIV_N_RST,
    parameter int DIV_M = DIV_M_RST
)(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_frame_valid,
    input wire logic [FRAME_W-1:0] i_frame,
    input wire logic i_enable,
    output logic o_resp_valid,
    output logic [FRAME_W-1:0] o_resp,
    output logic [NUM_CHANNELS-1:0] o_channel_run,
    output logic [NUM_CHANNELS*KP_W-1:0] o_kp,
    output logic [NUM_CHANNELS*KI_W-1:0] o_ki,
    output logic [NUM_CHANNELS*TARGET_W-1:0] o_target,
    output logic o_pwm_tick
);
    logic [KP_W-1:0] kp_r [NUM_CHANNELS];
    logic [KI_W-1:0] ki_r [NUM_CHANNELS];
    logic hold_r [NUM_CHANNELS];
    logic [STEP_W-1:0] step_r [NUM_CHANNELS];
    logic [SETPT_W-1:0] setpt_r [NUM_CHANNELS];
    logic [NSTEPS_W-1:0] nsteps_r [NUM_CHANNELS];
    logic [PWM_CNT_W-1:0] pwm_cnt_r;

    frame_t frm;
    logic is_write;
    logic hit_gain;
    logic hit_setpt;
    logic hit_nsteps;
    logic [2:0] ch;
    logic [23:0] rd_body;
    logic [FRAME_W-1:0] resp_nxt;
    localparam logic [PWM_CNT_W-1:0] PWM_LAST = PWM_CNT_W'(DIV_N * DIV_M - 1);

    assign frm = frame_t'(i_frame);
    assign ch = frm.channel_select;
    assign is_write = i_frame_valid && (frm.rw == RW_WRITE);
    assign hit_gain = frm.message_identifier == MSG_LOOP_GAIN;
    assign hit_setpt = frm.message_identifier == MSG_SETPOINT;
    assign hit_nsteps = frm.message_identifier == MSG_DITHER_PERIOD;

    // read data in write-frame positions, holes left at zero
    assign rd_body = hit_gain ? {kp_r[ch], ki_r[ch]} :
                     hit_setpt ? {hold_r[ch], 1'b0, step_r[ch], setpt_r[ch]} :
                     hit_nsteps ? {19'h0_0000, nsteps_r[ch]} : 24'h00_0000;
    assign resp_nxt = {RW_READ, frm.message_identifier, frm.channel_select, rd_body};

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_resp_valid <= 1'b0;
            o_resp <= '0;
        end else begin
            o_resp_valid <= i_frame_valid;
            if (i_frame_valid) begin
                o_resp <= resp_nxt;
            end
        end
    end

    // free running pwm period divider; n*m fits well inside the 24-bit package counter width, n and m are parameters
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pwm_cnt_r <= '0;
            o_pwm_tick <= 1'b0;
        end else begin
            o_pwm_tick <= (pwm_cnt_r == PWM_LAST);
            pwm_cnt_r <= (pwm_cnt_r == PWM_LAST) ? '0 : pwm_cnt_r + 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CHANNELS; g++) begin : g_channel
            logic sel;
            logic signed [TARGET_W-1:0] tgt;
            assign sel = is_write && (ch == 3'(g));

            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    kp_r[g] <= KP_RST;
                    ki_r[g] <= KI_RST;
                end else if (sel && hit_gain) begin
                    kp_r[g] <= frm.body[KP_LSB +: KP_W];
                    ki_r[g] <= frm.body[KI_LSB +: KI_W];
                end
            end

            // bit 22 of the setpoint body is dropped on write
            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    hold_r[g] <= HOLD_RST;
                    step_r[g] <= STEP_RST;
                    setpt_r[g] <= SETPT_RST;
                end else if (sel && hit_setpt) begin
                    hold_r[g] <= frm.body[HOLD_BIT];
                    step_r[g] <= frm.body[STEP_LSB +: STEP_W];
                    setpt_r[g] <= frm.body[SETPT_LSB +: SETPT_W];
                end
            end

            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    nsteps_r[g] <= NSTEPS_RST;
                end else if (sel && hit_nsteps) begin
                    nsteps_r[g] <= frm.body[NSTEPS_LSB +: NSTEPS_W];
                end
            end

            dither_wave u_wave (
                .i_ref_clk(i_ref_clk),
                .i_rst(i_rst),
                .i_pwm_tick(o_pwm_tick),
                .i_step(step_r[g]),
                .i_nsteps(nsteps_r[g]),
                .i_setpoint(setpt_r[g]),
                .o_target(tgt)
            );
            assign o_target[g*TARGET_W +: TARGET_W] = tgt;

            // outputs straight from the setting flops; run is registered
            assign o_kp[g*KP_W +: KP_W] = kp_r[g];
            assign o_ki[g*KI_W +: KI_W] = ki_r[g];
            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    o_channel_run[g] <= 1'b0;
                end else begin
                    o_channel_run[g] <= i_enable || hold_r[g];
                end
            end
        end
    endgenerate
endmodule

// file: sim/loop_dither_settings_sva.sv
/*
 checker for the settings store, seeing only its top ports.
 assumes one clock domain and the short divider values handed on by the bind.
*/
`timescale 1ns/1ps
module loop_dither_settings_chk
    import loop_dither_pkg::*;
#(
    parameter int DIV_N = DIV_N_RST,
    parameter int DIV_M = DIV_M_RST
)(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_frame_valid,
    input wire logic [FRAME_W-1:0] i_frame,
    input wire logic i_enable,
    input wire logic o_resp_valid,
    input wire logic [FRAME_W-1:0] o_resp,
    input wire logic [NUM_CHANNELS-1:0] o_channel_run,
    input wire logic [NUM_CHANNELS*KP_W-1:0] o_kp,
    input wire logic [NUM_CHANNELS*KI_W-1:0] o_ki,
    input wire logic o_pwm_tick
);
    // clocks since the last tick; a register so the period is checked without long repetitions
    logic [PWM_CNT_W-1:0] cnt_r;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) cnt_r <= '0;
        else cnt_r <= o_pwm_tick ? PWM_CNT_W'(1) : cnt_r + 1'b1;
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_take; i_frame_valid; endsequence
    sequence s_gain_wr; i_frame_valid && i_frame[31] && i_frame[30:27] == MSG_LOOP_GAIN; endsequence
    property p_answer; s_take |=> o_resp_valid && !o_resp[31] && o_resp[30:24] == $past(i_frame[30:24]); endproperty
    a_answer: assert property (p_answer) else $error("response late or header wrong");
    property p_quiet; !i_frame_valid |=> !o_resp_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("response without frame");
    property p_gain; s_gain_wr |=> o_kp[$past(i_frame[26:24])*KP_W +: KP_W] == $past(i_frame[23:12])
        && o_ki[$past(i_frame[26:24])*KI_W +: KI_W] == $past(i_frame[11:0]); endproperty
    a_gain: assert property (p_gain) else $error("gain not stored");
    property p_setpt_gap; i_frame_valid && i_frame[30:27] == MSG_SETPOINT |=> !o_resp[22]; endproperty
    a_setpt_gap: assert property (p_setpt_gap) else $error("setpoint spare bit set");
    property p_period_gap; i_frame_valid && i_frame[30:27] == MSG_DITHER_PERIOD |=> o_resp[23:5] == 19'h0_0000;
    endproperty
    a_period_gap: assert property (p_period_gap) else $error("step count spare bits set");
    property p_run; i_enable |=> &o_channel_run; endproperty
    a_run: assert property (p_run) else $error("channel stopped while enabled");
    property p_tick; o_pwm_tick == (cnt_r == DIV_N * DIV_M); endproperty
    a_tick: assert property (p_tick) else $error("pwm period wrong");
    property p_keep; i_frame_valid && (!i_frame[31] || i_frame[30:27] != MSG_LOOP_GAIN)
        |=> $stable(o_kp) && $stable(o_ki); endproperty
    a_keep: assert property (p_keep) else $error("gain changed by other frame");
endmodule
bind loop_dither_settings loop_dither_settings_chk #(.DIV_N(DIV_N), .DIV_M(DIV_M)) loop_dither_settings_chk_i (
    .i_ref_clk, .i_rst, .i_frame_valid, .i_frame, .i_enable, .o_resp_valid, .o_resp,
    .o_channel_run, .o_kp, .o_ki, .o_pwm_tick);

// file: sim/host_model.sv
/*
 host model: sends one command frame per call and hands back the response.
 assumes the store answers in the cycle after the taking edge.
*/
`timescale 1ns/1ps
module host_model(
    input wire logic i_ref_clk,
    input wire logic i_resp_valid,
    input wire logic [31:0] i_resp,
    output logic o_frame_valid,
    output logic [31:0] o_frame
);
    initial begin
        o_frame_valid = 1'b0;
        o_frame = 32'h0000_0000;
    end
    task automatic xfer(input logic [31:0] f, output logic [31:0] r);
        @(negedge i_ref_clk);
        o_frame_valid = 1'b1;
        o_frame = f;
        @(negedge i_ref_clk);
        o_frame_valid = 1'b0;
        o_frame = ~f; // idle bus never repeats the last frame
        r = i_resp_valid ? i_resp : 32'hxxxx_xxxx;
    endtask
endmodule

// file: sim/tb_loop_dither_settings.sv
/*
 testbench for the settings store: frames through the host model, outputs compared.
 assumes short dividers of 2 and 2, so a pwm tick every 4 clocks.
*/
`timescale 1ns/1ps
module tb_loop_dither_settings
    import loop_dither_pkg::*;
;
    logic i_ref_clk, i_rst, i_enable, fv, rv, tick;
    logic [31:0] fd, rd_d, r;
    logic [7:0] run;
    logic [95:0] kp, ki;
    logic [143:0] tg;
    logic signed [17:0] tmax, tmin;
    int mismatches = 0;
    int tests_run = 0;
    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    loop_dither_settings #(.DIV_N(2), .DIV_M(2)) loop_dither_settings_i (.i_ref_clk, .i_rst, .i_frame_valid(fv),
        .i_frame(fd), .i_enable, .o_resp_valid(rv), .o_resp(rd_d), .o_channel_run(run), .o_kp(kp), .o_ki(ki),
        .o_target(tg), .o_pwm_tick(tick));
    host_model host_model_i (.i_ref_clk, .i_resp_valid(rv), .i_resp(rd_d), .o_frame_valid(fv), .o_frame(fd));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [31:0] fr(logic w, logic [3:0] id, logic [2:0] ch, logic [23:0] b);
        return {w, id, ch, b};
    endfunction
    // write answers with the old body; read carries junk body that must be ignored
    task automatic wr(input logic [3:0] id, input logic [2:0] ch, input logic [23:0] b, input logic [23:0] old);
        host_model_i.xfer(fr(1'b1, id, ch, b), r);
        chk(r, fr(1'b0, id, ch, old));
    endtask
    task automatic rd(input logic [3:0] id, input logic [2:0] ch, input logic [23:0] exp);
        host_model_i.xfer(fr(1'b0, id, ch, 24'hff_ffff), r);
        chk(r, fr(1'b0, id, ch, exp));
    endtask
    initial begin
        i_rst = 1'b1;
        i_enable = 1'b0;
        repeat (6) @(negedge i_ref_clk);
        i_rst = 1'b0;
        for (int c = 0; c < 8; c += 7) begin
            rd(MSG_LOOP_GAIN, c[2:0], 24'h00_0000);
            rd(MSG_SETPOINT, c[2:0], 24'h00_0000);
            rd(MSG_DITHER_PERIOD, c[2:0], 24'h00_0000);
        end
        wr(MSG_LOOP_GAIN, 3'h2, 24'hff_f001, 24'h00_0000);
        wr(MSG_LOOP_GAIN, 3'h2, 24'h80_1fff, 24'hff_f001);
        rd(MSG_LOOP_GAIN, 3'h2, 24'h80_1fff);
        chk({8'h00, kp[35:24], ki[35:24]}, 32'h0080_1fff);
        chk({8'h00, kp[47:36], ki[23:12]}, 32'h0000_0000);
        wr(MSG_SETPOINT, 3'h5, 24'hff_ffff, 24'h00_0000);
        rd(MSG_SETPOINT, 3'h5, 24'hbf_ffff);
        repeat (10) @(negedge i_ref_clk);
        chk({14'h0000, tg[107:90]}, 32'h0000_1ffc);
        chk({24'h00_0000, run}, 32'h0000_0020);
        wr(MSG_SETPOINT, 3'h5, 24'h00_1864, 24'hbf_ffff);
        wr(MSG_DITHER_PERIOD, 3'h5, 24'hff_ffe3, 24'h00_0000);
        rd(MSG_DITHER_PERIOD, 3'h5, 24'h00_0003);
        tmax = 18'sh0_0000;
        tmin = 18'sh1_ffff;
        repeat (80) begin
            @(negedge i_ref_clk);
            tmax = $signed(tg[107:90]) > tmax ? $signed(tg[107:90]) : tmax;
            tmin = $signed(tg[107:90]) < tmin ? $signed(tg[107:90]) : tmin;
        end
        chk({14'h0000, tmax}, 32'h0000_0199);
        chk({14'h0000, tmin}, 32'h0000_0187);
        wr(MSG_SETPOINT, 3'h5, 24'h00_0064, 24'h00_1864);
        repeat (10) @(negedge i_ref_clk);
        chk({14'h0000, tg[107:90]}, 32'h0000_0190);
        i_enable = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        chk({24'h00_0000, run}, 32'h0000_00ff);
        close_out();
    end
    // the whole run is about 140 clocks; this cuts a hang at 4000
    initial begin
        #200_000;
        mismatches++;
        close_out();
    end
endmodule
